// File: ccsr_mdio_master.sv
// management-port master model that frames reads and writes for the lane register bank
module ccsr_mdio_master #(
    parameter logic [4:0] PHY = ccsr_pkg::PHY_ADDR_DFLT
) (
    input  wire logic sys_clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe_n,
    output logic      mdc,
    output logic      mdio_in
);
    import ccsr_pkg::*;
    logic m_en;
    logic m_val;

    // line level: device when it drives, else master, else the pull-up
    assign mdio_in = !mdio_oe_n ? mdio_out : (m_en ? m_val : 1'b1);

    initial begin
        mdc = 1'b0;
        m_en = 1'b0;
        m_val = 1'b1;
    end

    // one mdc period of four clocks; line changes while mdc is low, sampled before the rise
    task automatic clk_bit(input logic drv, input logic b, output logic s);
        @(posedge sys_clk);
        #1;
        mdc = 1'b0;
        m_en = drv;
        m_val = b;
        repeat (2) @(posedge sys_clk);
        #1;
        s = mdio_in;
        mdc = 1'b1;
        @(posedge sys_clk);
    endtask

    // whole frame with its own preamble; mdc stands low between frames
    task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] q);
        logic [45:0] hdr;
        logic        s;
        q = 16'h0000;
        hdr = {32'hFFFFFFFF, 2'b01, rd ? OP_READ : OP_WRITE, PHY, ra};
        for (int i = 45; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        for (int i = 17; i >= 0; i--) begin
            clk_bit(!rd, i == 17 || (i < 16 && wd[i]), s);
            if (i < 16) q[i] = s;
        end
        #1;
        mdc = 1'b0;
        m_en = 1'b0;
    endtask
endmodule

// File: ccsr_pkg.sv
// constants, field positions, reset values and frame states for the lane register bank
package ccsr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0]  LANE_C_CONFIG_OFS     = 5'h13;
    localparam logic [4:0]  LANE_D_CONFIG_OFS     = 5'h14;
    localparam logic [4:0]  LANE_STATUS_FLAGS_OFS = 5'h16;

    // ------------------------------------------------------------
    // lane configuration fields
    // ------------------------------------------------------------
    localparam int          CFG_PDOWN_POS   = 0;
    localparam int          CFG_COMMA_POS   = 1;
    localparam int          CFG_PRBS_POS    = 2;
    localparam int          CFG_LOOP_POS    = 3;
    localparam int          CFG_EMPH1_POS   = 4;
    localparam int          CFG_EMPH2_POS   = 5;
    localparam int          CFG_BIT0_POS    = 6;
    localparam int          CFG_BIT1_POS    = 7;
    localparam int          CFG_LOSEN_POS   = 8;
    localparam int          CFG_MSB         = 8;
    localparam logic [8:0]  LANE_CFG_RST    = 9'h102;

    // ------------------------------------------------------------
    // status fields (lsb of each four-lane group)
    // ------------------------------------------------------------
    localparam int          ST_LOS_POS      = 0;
    localparam int          ST_PASS_POS     = 4;
    localparam int          ST_DEC_POS      = 8;
    localparam int          ST_COLL_POS     = 12;
    localparam logic [15:0] STATUS_RST      = 16'h00F0;

    // ------------------------------------------------------------
    // management frame format
    // ------------------------------------------------------------
    localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
    localparam logic [4:0]  HDR_LAST_BIT    = 5'h0C;
    localparam logic [4:0]  DATA_LAST_BIT   = 5'h0F;
    localparam logic [4:0]  TA_LAST_BIT     = 5'h01;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [4:0]  PHY_ADDR_DFLT   = 5'h01;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HDR   = 3'b001,
        ST_TA_WR = 3'b010,
        ST_WDATA = 3'b011,
        ST_TA_RD = 3'b100,
        ST_RDATA = 3'b101
    } ccsr_state_t;
endpackage

// File: ccsr_regs.sv
// lane C/D configuration and shared lane status registers behind the management port
//
// How it works
// RQ1: lane loopback bit ORs with global loopback
// RQ2: lane pattern enable ORs with global enable
// RQ3: lane comma enable ORs global, resets enabled
// RQ4: lane power down ORs with global bit
// RQ5: loss-of-signal reporting gated, enabled after reset
// RQ6: two lane configuration bits 7:6, reset zero
// RQ7: two preemphasis bits 5:4, reset zero
// RQ8: collision flags 15:12, cleared on read
// RQ9: decode error flags 11:8, cleared on read
// RQ10: pass flags 7:4, error clears, read restores
// RQ11: loss-of-signal flags 3:0, cleared on read
// RQ12: effective config is pin, global, lane OR
// RQ13: lane loopback also ORs dedicated pin
// RQ14: reserved config bits read zero, ignore writes
// RQ15: flags stay set until status read
module ccsr_regs #(
    parameter logic [4:0] PHY_ADDR = ccsr_pkg::PHY_ADDR_DFLT
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    input  wire logic [1:0]  cfg_pin,
    input  wire logic        loopback_pin_c,
    input  wire logic        loopback_pin_d,
    input  wire logic [1:0]  glb_cfg,
    input  wire logic        glb_loopback,
    input  wire logic        glb_prbs_en,
    input  wire logic        glb_comma_en,
    input  wire logic        glb_power_down,
    input  wire logic [1:0]  los_report_en_ab,
    input  wire logic [3:0]  fifo_coll_evt,
    input  wire logic [3:0]  decode_err_evt,
    input  wire logic [3:0]  prbs_err_evt,
    input  wire logic [3:0]  loss_of_signal,
    output logic [1:0]       lane_c_cfg,
    output logic [1:0]       lane_d_cfg,
    output logic [1:0]       lane_c_emph,
    output logic [1:0]       lane_d_emph,
    output logic             lane_c_loopback,
    output logic             lane_d_loopback,
    output logic             lane_c_prbs_en,
    output logic             lane_d_prbs_en,
    output logic             lane_c_comma_en,
    output logic             lane_d_comma_en,
    output logic             lane_c_power_down,
    output logic             lane_d_power_down
);
    import ccsr_pkg::*;

    // ------------------------------------------------------------
    // management frame decoder
    // ------------------------------------------------------------
    ccsr_state_t  state_ff;
    logic         mdc_d_ff;
    logic [5:0]   ones_cnt_ff;
    logic [4:0]   bit_cnt_ff;
    logic [15:0]  sh_ff;
    logic [4:0]   reg_addr_ff;
    logic [15:0]  rd_sh_ff;
    logic [8:0]   cfg_c_ff;
    logic [8:0]   cfg_d_ff;
    logic [15:0]  status_ff;

    logic         mdc_rise;
    logic [12:0]  hdr_word;
    logic [15:0]  wdata;
    logic         hdr_done;
    logic         hdr_ok;
    logic         read_hit;
    logic         wr_done;
    logic [15:0]  rd_value;
    logic         status_rd;
    logic [3:0]   los_gate;

    // mdc is taken as synchronous, so one delay stage is enough for the edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mdc_d_ff <= 1'b0;
        end else begin
            mdc_d_ff <= mdc;
        end
    end

    assign mdc_rise  = mdc & ~mdc_d_ff;
    assign hdr_word  = {sh_ff[11:0], mdio_in};
    assign wdata     = {sh_ff[14:0], mdio_in};
    assign hdr_done  = (state_ff == ST_HDR) && mdc_rise && (bit_cnt_ff == HDR_LAST_BIT);
    // header: second start bit, op code, phy address, register address
    assign hdr_ok    = hdr_word[12] && (hdr_word[9:5] == PHY_ADDR);
    assign read_hit  = hdr_done && hdr_ok && (hdr_word[11:10] == OP_READ);
    assign wr_done   = (state_ff == ST_WDATA) && mdc_rise && (bit_cnt_ff == DATA_LAST_BIT);
    assign status_rd = read_hit && (hdr_word[4:0] == LANE_STATUS_FLAGS_OFS);

    // read mux; reserved config bits and unmapped addresses give zero
    always_comb begin
        rd_value = 16'h0000;
        case (hdr_word[4:0])
            LANE_C_CONFIG_OFS:     rd_value = {7'h00, cfg_c_ff}; // [RQ14]
            LANE_D_CONFIG_OFS:     rd_value = {7'h00, cfg_d_ff}; // [RQ14]
            LANE_STATUS_FLAGS_OFS: rd_value = status_ff;
            default:               rd_value = 16'h0000;
        endcase
    end

    // frame sequencer; a bad start, op or address drops back to preamble hunt
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= ST_IDLE;
            ones_cnt_ff <= 6'h00;
            bit_cnt_ff  <= 5'h00;
            sh_ff       <= 16'h0000;
            reg_addr_ff <= 5'h00;
        end else if (mdc_rise) begin
            sh_ff      <= wdata;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            case (state_ff)
                ST_IDLE: begin
                    bit_cnt_ff <= 5'h00;
                    if (mdio_in) begin
                        if (ones_cnt_ff != PREAMBLE_LEN) begin
                            ones_cnt_ff <= ones_cnt_ff + 6'h01;
                        end
                    end else begin
                        if (ones_cnt_ff == PREAMBLE_LEN) begin
                            state_ff <= ST_HDR;
                        end
                        ones_cnt_ff <= 6'h00;
                    end
                end
                ST_HDR: begin
                    if (bit_cnt_ff == HDR_LAST_BIT) begin
                        bit_cnt_ff  <= 5'h00;
                        reg_addr_ff <= hdr_word[4:0];
                        if (read_hit) begin
                            state_ff <= ST_TA_RD;
                        end else if (hdr_ok && (hdr_word[11:10] == OP_WRITE)) begin
                            state_ff <= ST_TA_WR;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_TA_WR: begin
                    if (bit_cnt_ff == TA_LAST_BIT) begin
                        bit_cnt_ff <= 5'h00;
                        state_ff   <= ST_WDATA;
                    end
                end
                ST_TA_RD: begin
                    if (bit_cnt_ff == TA_LAST_BIT) begin
                        bit_cnt_ff <= 5'h00;
                        state_ff   <= ST_RDATA;
                    end
                end
                ST_WDATA, ST_RDATA: begin
                    if (bit_cnt_ff == DATA_LAST_BIT) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // read data path: drive zero in the second turnaround bit, then msb first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_sh_ff  <= 16'h0000;
            mdio_out  <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (read_hit) begin
            rd_sh_ff <= rd_value;
        end else if (mdc_rise) begin
            if (state_ff == ST_TA_RD && bit_cnt_ff == 5'h00) begin
                mdio_out  <= 1'b0;
                mdio_oe_n <= 1'b0;
            end else if (state_ff == ST_TA_RD || state_ff == ST_RDATA) begin
                if (state_ff == ST_RDATA && bit_cnt_ff == DATA_LAST_BIT) begin
                    mdio_out  <= 1'b1;
                    mdio_oe_n <= 1'b1;
                end else begin
                    mdio_out <= rd_sh_ff[15];
                    rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // lane configuration registers
    // ------------------------------------------------------------
    // only the low nine bits exist, so reserved bits cannot take writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_c_ff <= LANE_CFG_RST; // [RQ3] [RQ5] [RQ6] [RQ7]
            cfg_d_ff <= LANE_CFG_RST; // [RQ1] [RQ2] [RQ4]
        end else if (wr_done) begin
            if (reg_addr_ff == LANE_C_CONFIG_OFS) begin
                cfg_c_ff <= wdata[CFG_MSB:0]; // [RQ6] [RQ7] [RQ14]
            end
            if (reg_addr_ff == LANE_D_CONFIG_OFS) begin
                cfg_d_ff <= wdata[CFG_MSB:0]; // [RQ6] [RQ7] [RQ14]
            end
        end
    end

    // effective lane controls, registered so every output is a flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lane_c_cfg        <= 2'h0;
            lane_d_cfg        <= 2'h0;
            lane_c_emph       <= 2'h0;
            lane_d_emph       <= 2'h0;
            lane_c_loopback   <= 1'b0;
            lane_d_loopback   <= 1'b0;
            lane_c_prbs_en    <= 1'b0;
            lane_d_prbs_en    <= 1'b0;
            lane_c_comma_en   <= 1'b1;
            lane_d_comma_en   <= 1'b1;
            lane_c_power_down <= 1'b0;
            lane_d_power_down <= 1'b0;
        end else begin
            lane_c_cfg <= cfg_pin | glb_cfg | cfg_c_ff[CFG_BIT1_POS:CFG_BIT0_POS]; // [RQ12]
            lane_d_cfg <= cfg_pin | glb_cfg | cfg_d_ff[CFG_BIT1_POS:CFG_BIT0_POS]; // [RQ12]
            lane_c_emph <= cfg_c_ff[CFG_EMPH2_POS:CFG_EMPH1_POS]; // [RQ7]
            lane_d_emph <= cfg_d_ff[CFG_EMPH2_POS:CFG_EMPH1_POS]; // [RQ7]
            lane_c_loopback <= loopback_pin_c | glb_loopback
                               | cfg_c_ff[CFG_LOOP_POS]; // [RQ1] [RQ13]
            lane_d_loopback <= loopback_pin_d | glb_loopback
                               | cfg_d_ff[CFG_LOOP_POS]; // [RQ1] [RQ13]
            lane_c_prbs_en    <= glb_prbs_en | cfg_c_ff[CFG_PRBS_POS];     // [RQ2]
            lane_d_prbs_en    <= glb_prbs_en | cfg_d_ff[CFG_PRBS_POS];     // [RQ2]
            lane_c_comma_en   <= glb_comma_en | cfg_c_ff[CFG_COMMA_POS];   // [RQ3]
            lane_d_comma_en   <= glb_comma_en | cfg_d_ff[CFG_COMMA_POS];   // [RQ3]
            lane_c_power_down <= glb_power_down | cfg_c_ff[CFG_PDOWN_POS]; // [RQ4]
            lane_d_power_down <= glb_power_down | cfg_d_ff[CFG_PDOWN_POS]; // [RQ4]
        end
    end

    // ------------------------------------------------------------
    // shared status flags
    // ------------------------------------------------------------
    // lanes a/b enables live elsewhere; c/d come from their own registers
    assign los_gate = {cfg_d_ff[CFG_LOSEN_POS], cfg_c_ff[CFG_LOSEN_POS], los_report_en_ab};

    // the read samples the old value first; an event in the read cycle still lands
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_ff <= STATUS_RST;
        end else begin
            status_ff[ST_COLL_POS+:4] <= (status_ff[ST_COLL_POS+:4] & {4{~status_rd}})
                                         | fifo_coll_evt;             // [RQ8] [RQ15]
            status_ff[ST_DEC_POS+:4]  <= (status_ff[ST_DEC_POS+:4] & {4{~status_rd}})
                                         | decode_err_evt;            // [RQ9] [RQ15]
            status_ff[ST_PASS_POS+:4] <= (status_ff[ST_PASS_POS+:4] | {4{status_rd}})
                                         & ~prbs_err_evt;             // [RQ10]
            status_ff[ST_LOS_POS+:4]  <= (status_ff[ST_LOS_POS+:4] & {4{~status_rd}})
                                         | (loss_of_signal & los_gate); // [RQ5] [RQ11] [RQ15]
        end
    end
endmodule

// File: ccsr_regs_checker.sv
// concurrent checks on the lane register bank ports
module ccsr_regs_checker (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [1:0] cfg_pin,
    input wire logic       loopback_pin_c,
    input wire logic       loopback_pin_d,
    input wire logic [1:0] glb_cfg,
    input wire logic       glb_loopback,
    input wire logic       glb_prbs_en,
    input wire logic       glb_comma_en,
    input wire logic       glb_power_down,
    input wire logic [1:0] lane_c_cfg,
    input wire logic [1:0] lane_d_cfg,
    input wire logic [1:0] lane_c_emph,
    input wire logic [1:0] lane_d_emph,
    input wire logic       lane_c_loopback,
    input wire logic       lane_d_loopback,
    input wire logic       lane_c_prbs_en,
    input wire logic       lane_d_prbs_en,
    input wire logic       lane_c_comma_en,
    input wire logic       lane_d_comma_en,
    input wire logic       lane_c_power_down,
    input wire logic       lane_d_power_down
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // global and pin controls can only force lane outputs on, one clock later
    a_loop_c_or: assert property (
        (loopback_pin_c | glb_loopback) |=> lane_c_loopback)
        else $error("lane c loopback not forced on");
    a_loop_d_or: assert property ((loopback_pin_d | glb_loopback) |=> lane_d_loopback)
        else $error("lane d loopback not forced on");
    a_prbs_glb: assert property (glb_prbs_en |=> lane_c_prbs_en && lane_d_prbs_en)
        else $error("pattern enable not forced on");
    a_comma_glb: assert property (glb_comma_en |=> lane_c_comma_en && lane_d_comma_en)
        else $error("comma enable not forced on");
    a_pdown_glb: assert property (
        glb_power_down |=> lane_c_power_down && lane_d_power_down)
        else $error("power down not forced on");
    a_cfg_pin_or: assert property (
        cfg_pin != 2'h0 |=> (lane_c_cfg & lane_d_cfg & $past(cfg_pin)) == $past(cfg_pin))
        else $error("config pin not passed to lanes");
    a_cfg_glb_or: assert property (
        glb_cfg != 2'h0 |=> (lane_d_cfg & $past(glb_cfg)) == $past(glb_cfg))
        else $error("global config not passed to lane d");
    // sampled values at the release edge are still the reset state
    a_reset_vals: assert property (
        $rose(rstn) |-> lane_c_comma_en && lane_d_comma_en
                        && lane_c_emph == 2'h0 && lane_d_emph == 2'h0)
        else $error("lane outputs wrong after reset");
endmodule

bind ccsr_regs ccsr_regs_checker u_chk (.sys_clk, .rstn, .cfg_pin, .loopback_pin_c,
    .loopback_pin_d, .glb_cfg, .glb_loopback, .glb_prbs_en, .glb_comma_en, .glb_power_down,
    .lane_c_cfg, .lane_d_cfg, .lane_c_emph, .lane_d_emph, .lane_c_loopback, .lane_d_loopback,
    .lane_c_prbs_en, .lane_d_prbs_en, .lane_c_comma_en, .lane_d_comma_en,
    .lane_c_power_down, .lane_d_power_down);

// File: testbench.sv
// self-checking bench for the lane register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ccsr_pkg::*;
    logic        sys_clk, rstn, mdc, mdio_in, mdio_out, mdio_oe_n;
    logic        loopback_pin_c, loopback_pin_d, glb_loopback, glb_prbs_en;
    logic        glb_comma_en, glb_power_down, lane_c_loopback, lane_d_loopback;
    logic        lane_c_prbs_en, lane_d_prbs_en, lane_c_comma_en, lane_d_comma_en;
    logic        lane_c_power_down, lane_d_power_down;
    logic [1:0]  cfg_pin, glb_cfg, los_report_en_ab, lane_c_cfg, lane_d_cfg;
    logic [1:0]  lane_c_emph, lane_d_emph;
    logic [3:0]  fifo_coll_evt, decode_err_evt, prbs_err_evt, loss_of_signal;
    logic [7:0]  gsel, c_out, d_out;
    logic [15:0] rd;
    int          mismatches, n_checks, cycles;

    // lane outputs packed in the same bit order as the config register
    assign c_out = {lane_c_cfg, lane_c_emph, lane_c_loopback, lane_c_prbs_en, lane_c_comma_en,
                    lane_c_power_down};
    assign d_out = {lane_d_cfg, lane_d_emph, lane_d_loopback, lane_d_prbs_en, lane_d_comma_en,
                    lane_d_power_down};
    assign {glb_cfg, glb_loopback, glb_prbs_en, glb_comma_en, glb_power_down} =
        {gsel[7:6], gsel[3:0]};

    ccsr_regs dut (.sys_clk, .rstn, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .cfg_pin,
        .loopback_pin_c, .loopback_pin_d, .glb_cfg, .glb_loopback, .glb_prbs_en, .glb_comma_en,
        .glb_power_down, .los_report_en_ab, .fifo_coll_evt, .decode_err_evt, .prbs_err_evt,
        .loss_of_signal, .lane_c_cfg, .lane_d_cfg, .lane_c_emph, .lane_d_emph, .lane_c_loopback,
        .lane_d_loopback, .lane_c_prbs_en, .lane_d_prbs_en, .lane_c_comma_en, .lane_d_comma_en,
        .lane_c_power_down, .lane_d_power_down);
    ccsr_mdio_master m (.sys_clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);

    always #5 sys_clk = ~sys_clk;

    // a hung frame would stall forever; whole run needs about 3400 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        m.xfer(1'b1, a, 16'h0000, rd);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        rdchk(LANE_C_CONFIG_OFS, 16'h0102);
        rdchk(LANE_D_CONFIG_OFS, 16'h0102);
        chk({c_out, d_out}, 16'h0202);
        $display("reset values done");
    endtask

    // reserved bits, every lane field, then each global bit and pin on lane d
    task automatic t_cfg();
        m.xfer(1'b0, LANE_C_CONFIG_OFS, 16'hFFFF, rd);
        rdchk(LANE_C_CONFIG_OFS, 16'h01FF);
        chk({8'h00, c_out}, 16'h00FF);
        m.xfer(1'b0, LANE_D_CONFIG_OFS, 16'h0000, rd);
        rdchk(LANE_D_CONFIG_OFS, 16'h0000);
        chk({8'h00, d_out}, 16'h0000);
        foreach (gsel[b]) begin
            gsel = 8'h01 << b;
            tick(2);
            chk({8'h00, d_out}, {8'h00, gsel & 8'hCF});
        end
        gsel = 8'h00;
        cfg_pin = 2'h3;
        loopback_pin_d = 1'b1;
        tick(2);
        chk({8'h00, d_out}, 16'h00C8);
        // pins back to idle so the later lane c checks see only their own inputs
        cfg_pin = 2'h0;
        loopback_pin_d = 1'b0;
        tick(2);
        chk({8'h00, d_out}, 16'h0000);
        $display("config test done");
    endtask

    // one event per kind, loss of signal on all four lanes, lane b and lane d loss-of-signal reporting off
    task automatic t_status();
        rdchk(LANE_STATUS_FLAGS_OFS, 16'h00F0);
        fifo_coll_evt = 4'h8;
        decode_err_evt = 4'h4;
        prbs_err_evt = 4'h2;
        loss_of_signal = 4'hF;
        los_report_en_ab = 2'b01;
        tick(1);
        {fifo_coll_evt, decode_err_evt, prbs_err_evt, loss_of_signal} = 16'h0000;
        tick(5);
        rdchk(LANE_STATUS_FLAGS_OFS, 16'h84D5);
        rdchk(LANE_STATUS_FLAGS_OFS, 16'h00F0);
        m.xfer(1'b0, LANE_STATUS_FLAGS_OFS, 16'hFFFF, rd);
        rdchk(5'h15, 16'h0000);
        rdchk(LANE_STATUS_FLAGS_OFS, 16'h00F0);
        m.xfer(1'b0, LANE_C_CONFIG_OFS, 16'h0100, rd);
        loopback_pin_c = 1'b1;
        tick(3);
        chk({8'h00, c_out}, 16'h0008);
        $display("status test done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {sys_clk, rstn, loopback_pin_c, loopback_pin_d, cfg_pin, los_report_en_ab} = 8'h00;
        {fifo_coll_evt, decode_err_evt, prbs_err_evt, loss_of_signal} = 16'h0000;
        gsel = 8'h00;
        tick(2);
        rstn = 1'b1;
        t_reset();
        t_cfg();
        t_status();
        end_of_test();
    end
endmodule
